// File: common/ard_pkg.sv
package ard_pkg;
   localparam logic [7:0] CMD_NOP = 8'h00;
   localparam logic [7:0] CMD_RD_BUF = 8'he4;
   localparam logic [7:0] CMD_RD_DMA = 8'hc8;
   localparam logic [7:0] CMD_RD_MULT = 8'hc4;
   localparam logic [7:0] CMD_RD_LONG0 = 8'h22;
   localparam logic [7:0] CMD_RD_LONG1 = 8'h23;
   localparam logic [7:0] CMD_NATIVE_MAX = 8'hf8;
   localparam int DH_DRIVE_BIT = 4;
   localparam int BUF_WORDS = 256;
   localparam int FIFO_DEPTH = 2;
   localparam int FIFO_W = 17;
   localparam logic [1:0] FIFO_FULL = 2'h2;
   localparam logic [8:0] SECT_WORDS = 9'h100;
   localparam logic [8:0] ECC_BYTES = 9'h004;
   localparam logic [8:0] MAX_SECT = 9'h100;
   localparam logic [8:0] ONE_SECT = 9'h001;
   localparam logic [7:0] MAX_MULT = 8'h01;
   localparam logic [7:0] ERR_ABRT = 8'h04;
   localparam logic [7:0] ERR_UNC = 8'h40;
   typedef enum logic [1:0] {
      DS_IDLE = 2'b00, DS_FETCH = 2'b01, DS_XFER = 2'b11, DS_DONE = 2'b10
   } ard_dstate_t;
   typedef enum logic [1:0] {
      HS_IDLE = 2'b00, HS_ISSUE = 2'b01, HS_WAIT = 2'b11, HS_END = 2'b10
   } ard_hstate_t;
   typedef enum logic [2:0] {
      MD_NONE = 3'h0, MD_BUF = 3'h1, MD_DMA = 3'h2, MD_MULT = 3'h3, MD_LONG = 3'h4
   } ard_mode_t;
endpackage

// File: common/ard_link_if.sv
`timescale 1ns/100ps
`default_nettype none
interface ard_link_if;
   logic cmd_stb;
   logic [7:0] cmd;
   logic [7:0] dev_head;
   logic [7:0] cyl_hi;
   logic [7:0] cyl_lo;
   logic [7:0] sec_num;
   logic [7:0] sec_cnt;
   logic bsy;
   logic drq;
   logic dmarq;
   logic err;
   logic corr;
   logic intrq;
   logic [7:0] err_reg;
   logic [7:0] tf_head;
   logic [7:0] tf_cyl_hi;
   logic [7:0] tf_cyl_lo;
   logic [7:0] tf_sec_num;
   logic [15:0] data;
   logic data_byte;
   logic data_valid;
   logic data_ready;
   modport dev (
      input cmd_stb, cmd, dev_head, cyl_hi, cyl_lo, sec_num, sec_cnt, data_ready,
      output bsy, drq, dmarq, err, corr, intrq, err_reg, tf_head, tf_cyl_hi,
      output tf_cyl_lo, tf_sec_num, data, data_byte, data_valid
   );
   modport host (
      output cmd_stb, cmd, dev_head, cyl_hi, cyl_lo, sec_num, sec_cnt, data_ready,
      input bsy, drq, dmarq, err, corr, intrq, err_reg, tf_head, tf_cyl_hi,
      input tf_cyl_lo, tf_sec_num, data, data_byte, data_valid
   );
endinterface
`default_nettype wire

// File: core/ard_dev_end.sv
`timescale 1ns/100ps
`default_nettype none
module ard_dev_end import ard_pkg::*; (
   input wire logic clock,
   input wire logic arst_n,
   ard_link_if.dev link,
   input wire logic drive_num,
   input wire logic mult_enable,
   input wire logic [7:0] mult_count,
   input wire logic [27:0] native_max,
   output logic media_req,
   output logic [27:0] media_lba,
   input wire logic [15:0] media_word,
   input wire logic media_valid,
   output logic media_ready,
   input wire logic media_err_corr,
   input wire logic media_err_unc,
   output logic [7:0] ident_max_mult
);
   // ****************************************
   // Declarations
   // ****************************************
   ard_dstate_t state_q;
   ard_mode_t mode_q;
   ard_mode_t mode_d;
   logic [27:0] lba_q;
   logic [3:0] dh_hi_q;
   logic [8:0] rem_q;
   logic [8:0] in_cnt_q;
   logic [8:0] out_cnt_q;
   logic [8:0] total;
   logic [7:0] blk_sz;
   logic [7:0] blk_left_q;
   logic [15:0] buf_mem [0:BUF_WORDS-1];
   logic [FIFO_W-1:0] fifo_q [0:FIFO_DEPTH-1];
   logic [1:0] cnt_q;
   logic [1:0] cnt_d;
   logic [1:0] wr_idx;
   logic fill_q;
   logic fill_d;
   logic stop_q;
   logic bsy_q, drq_q, dmarq_q, err_q, corr_q, intrq_q, dvalid_q;
   logic [7:0] err_reg_q;
   logic media_req_q, media_ready_q;
   logic [7:0] ident_q;
   logic accept, start, abort, mult_ok;
   logic push, push_med, push_buf, pop, first_push, last_in, last_out, more;
   logic in_byte, bad_unc, bad_corr, blk_irq;
   logic [15:0] in_word;

   // ****************************************
   // Command decode
   // ****************************************
   assign accept = (state_q == DS_IDLE) && link.cmd_stb
                   && (link.dev_head[DH_DRIVE_BIT] == drive_num);
   assign mult_ok = mult_enable && (mult_count != 8'h00);
   assign blk_sz = (mult_count > MAX_MULT) ? MAX_MULT : mult_count;

   always_comb begin
      mode_d = MD_NONE;
      case (link.cmd)
         CMD_RD_BUF: mode_d = MD_BUF;
         CMD_RD_DMA: mode_d = MD_DMA;
         CMD_RD_MULT: mode_d = mult_ok ? MD_MULT : MD_NONE;
         CMD_RD_LONG0, CMD_RD_LONG1: mode_d = MD_LONG;
         default: mode_d = MD_NONE;
      endcase
   end

   assign start = accept && (mode_d != MD_NONE);
   assign abort = accept && ((link.cmd == CMD_NOP)
                  || ((link.cmd == CMD_RD_MULT) && !mult_ok));

   // ****************************************
   // Data path
   // ****************************************
   assign total = (mode_q == MD_LONG) ? SECT_WORDS + ECC_BYTES : SECT_WORDS;
   assign push_med = fill_q && (mode_q != MD_BUF) && media_valid && media_ready_q;
   assign push_buf = fill_q && (mode_q == MD_BUF) && (cnt_q != FIFO_FULL);
   assign push = push_med || push_buf;
   assign pop = dvalid_q && link.data_ready;
   assign in_word = (mode_q == MD_BUF) ? buf_mem[in_cnt_q[7:0]] : media_word;
   assign in_byte = (in_cnt_q >= SECT_WORDS);
   assign last_in = push && (in_cnt_q == total - ONE_SECT);
   assign last_out = pop && (out_cnt_q == total - ONE_SECT);
   assign first_push = push && (in_cnt_q == 9'h000);
   assign more = (rem_q != ONE_SECT) && !stop_q;
   // Long read skips the ECC check; buffer read has no media behind it
   assign bad_unc = first_push && media_err_unc
                    && (mode_q != MD_LONG) && (mode_q != MD_BUF);
   assign bad_corr = first_push && media_err_corr
                     && (mode_q != MD_LONG) && (mode_q != MD_BUF);
   assign blk_irq = (mode_q == MD_BUF) || (mode_q == MD_LONG)
                    || ((mode_q == MD_MULT) && (blk_left_q == 8'h00));
   assign fill_d = start || (last_out && more) || (fill_q && !last_in);

   always_comb begin
      cnt_d = cnt_q;
      wr_idx = cnt_q;
      if (push && !pop) begin
         cnt_d = cnt_q + 2'h1;
      end else if (pop && !push) begin
         cnt_d = cnt_q - 2'h1;
      end
      if (pop) begin
         wr_idx = cnt_q - 2'h1;
      end
   end

   // ****************************************
   // Two-entry output buffer
   // ****************************************
   for (genvar i = 0; i < FIFO_DEPTH; i++) begin : g_ent
      always_ff @(posedge clock or negedge arst_n) begin
         if (!arst_n) begin
            fifo_q[i] <= '0;
         end else if (push && (wr_idx == 2'(i))) begin
            fifo_q[i] <= {in_byte, in_word};
         end else if (pop && (i < FIFO_DEPTH - 1)) begin
            fifo_q[i] <= fifo_q[(i + 1) % FIFO_DEPTH];
         end
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         cnt_q <= 2'h0;
         dvalid_q <= 1'b0;
         fill_q <= 1'b0;
         media_ready_q <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         dvalid_q <= (cnt_d != 2'h0);
         fill_q <= fill_d;
         // Only offered while the buffer will surely be empty next cycle
         media_ready_q <= fill_d && !last_in && (cnt_d == 2'h0)
                          && (start ? (mode_d != MD_BUF) : (mode_q != MD_BUF));
      end
   end

   // Sector buffer keeps the last sector, flawed or not
   always_ff @(posedge clock) begin
      if (push_med && !in_byte) begin
         buf_mem[in_cnt_q[7:0]] <= media_word;
      end
   end

   // ****************************************
   // Sequencer
   // ****************************************
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         state_q <= DS_IDLE;
         mode_q <= MD_NONE;
      end else begin
         case (state_q)
            DS_IDLE: begin
               if (start) begin
                  state_q <= DS_FETCH;
                  mode_q <= mode_d;
               end else if (abort || (accept && (link.cmd == CMD_NATIVE_MAX))) begin
                  state_q <= DS_DONE;
                  mode_q <= MD_NONE;
               end
            end
            DS_FETCH: begin
               if (first_push) begin
                  state_q <= DS_XFER;
               end
            end
            DS_XFER: begin
               if (last_out) begin
                  state_q <= more ? DS_FETCH : DS_DONE;
               end
            end
            DS_DONE: state_q <= DS_IDLE;
            default: state_q <= DS_IDLE;
         endcase
      end
   end

   // ****************************************
   // Address and counters
   // ****************************************
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         lba_q <= '0;
         dh_hi_q <= 4'h0;
         rem_q <= 9'h000;
      end else if (accept && (link.cmd == CMD_NATIVE_MAX)) begin
         dh_hi_q <= link.dev_head[7:4];
         lba_q <= native_max;
      end else if (start) begin
         dh_hi_q <= link.dev_head[7:4];
         lba_q <= {link.dev_head[3:0], link.cyl_hi, link.cyl_lo, link.sec_num};
         if ((mode_d == MD_BUF) || (mode_d == MD_LONG)) begin
            rem_q <= ONE_SECT;
         end else begin
            rem_q <= (link.sec_cnt == 8'h00) ? MAX_SECT : {1'b0, link.sec_cnt};
         end
      end else if (last_out && more) begin
         // Address advances only when another sector follows
         lba_q <= lba_q + 28'h1;
         rem_q <= rem_q - ONE_SECT;
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         in_cnt_q <= 9'h000;
         out_cnt_q <= 9'h000;
      end else if (start || (last_out && more)) begin
         in_cnt_q <= 9'h000;
         out_cnt_q <= 9'h000;
      end else begin
         if (push) begin
            in_cnt_q <= in_cnt_q + ONE_SECT;
         end
         if (pop) begin
            out_cnt_q <= out_cnt_q + ONE_SECT;
         end
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         blk_left_q <= 8'h00;
      end else if (start) begin
         blk_left_q <= 8'h00;
      end else if (first_push && (mode_q == MD_MULT)) begin
         // Block boundaries; blk_sz is capped at MAX_MULT, so every block is one sector
         blk_left_q <= ((blk_left_q == 8'h00) ? blk_sz : blk_left_q) - 8'h01;
      end
   end

   // ****************************************
   // Status and interrupt
   // ****************************************
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         bsy_q <= 1'b0;
         drq_q <= 1'b0;
         dmarq_q <= 1'b0;
         stop_q <= 1'b0;
      end else if (start) begin
         bsy_q <= 1'b1;
         stop_q <= 1'b0;
      end else if (first_push) begin
         bsy_q <= 1'b0;
         drq_q <= 1'b1;
         dmarq_q <= (mode_q == MD_DMA);
         stop_q <= bad_unc;
      end else if (last_out) begin
         bsy_q <= more;
         drq_q <= 1'b0;
         dmarq_q <= 1'b0;
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         err_q <= 1'b0;
         corr_q <= 1'b0;
         err_reg_q <= 8'h00;
      end else if (abort) begin
         err_q <= 1'b1;
         corr_q <= 1'b0;
         err_reg_q <= ERR_ABRT;
      end else if (accept) begin
         err_q <= 1'b0;
         corr_q <= 1'b0;
         err_reg_q <= 8'h00;
      end else begin
         if (bad_unc) begin
            err_q <= 1'b1;
            err_reg_q <= err_reg_q | ERR_UNC;
         end
         if (bad_corr) begin
            corr_q <= 1'b1;
         end
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         intrq_q <= 1'b0;
      end else if (first_push) begin
         intrq_q <= blk_irq;
      end else if (state_q == DS_DONE) begin
         intrq_q <= (mode_q == MD_DMA) || (mode_q == MD_NONE);
      end else begin
         intrq_q <= 1'b0;
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         media_req_q <= 1'b0;
         ident_q <= 8'h00;
      end else begin
         media_req_q <= (start && (mode_d != MD_BUF))
                        || (last_out && more && (mode_q != MD_BUF));
         ident_q <= MAX_MULT;
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   assign link.bsy = bsy_q;
   assign link.drq = drq_q;
   assign link.dmarq = dmarq_q;
   assign link.err = err_q;
   assign link.corr = corr_q;
   assign link.intrq = intrq_q;
   assign link.err_reg = err_reg_q;
   assign link.tf_head = {dh_hi_q, lba_q[27:24]};
   assign link.tf_cyl_hi = lba_q[23:16];
   assign link.tf_cyl_lo = lba_q[15:8];
   assign link.tf_sec_num = lba_q[7:0];
   assign link.data = fifo_q[0][15:0];
   assign link.data_byte = fifo_q[0][16];
   assign link.data_valid = dvalid_q;
   assign media_req = media_req_q;
   assign media_lba = lba_q;
   assign media_ready = media_ready_q;
   assign ident_max_mult = ident_q;
endmodule // ard_dev_end
`default_nettype wire

// File: core/ard_host_end.sv
`timescale 1ns/100ps
`default_nettype none
module ard_host_end import ard_pkg::*; (
   input wire logic clock,
   input wire logic arst_n,
   ard_link_if.host link,
   input wire logic go,
   input wire logic [7:0] go_cmd,
   input wire logic [7:0] go_dev_head,
   input wire logic [7:0] go_cyl_hi,
   input wire logic [7:0] go_cyl_lo,
   input wire logic [7:0] go_sec_num,
   input wire logic [7:0] go_sec_cnt,
   input wire logic rx_stall,
   output logic busy,
   output logic [15:0] rx_word,
   output logic rx_byte,
   output logic rx_valid,
   output logic done,
   output logic done_err,
   output logic [7:0] done_err_reg,
   output logic [27:0] done_addr
);
   ard_hstate_t state_q;
   logic stb_q, dma_q, ready_q, rx_valid_q, rx_byte_q, done_q, done_err_q, busy_q;
   logic [7:0] cmd_q, dh_q, ch_q, cl_q, sn_q, sc_q, err_reg_q;
   logic [15:0] rx_word_q;
   logic [27:0] addr_q;
   logic taken, quiet;

   assign taken = link.data_valid && ready_q;
   assign quiet = !link.bsy && !link.drq && !link.dmarq && !link.data_valid;

   // ****************************************
   // Command issue
   // ****************************************
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         state_q <= HS_IDLE;
         stb_q <= 1'b0;
         dma_q <= 1'b0;
         busy_q <= 1'b0;
      end else begin
         case (state_q)
            HS_IDLE: begin
               if (go) begin
                  state_q <= HS_ISSUE;
                  stb_q <= 1'b1;
                  busy_q <= 1'b1;
                  // Channel is armed on the same edge that raises the strobe to the device
                  dma_q <= (go_cmd == CMD_RD_DMA);
               end
            end
            HS_ISSUE: begin
               stb_q <= 1'b0;
               busy_q <= dma_q;
               state_q <= HS_WAIT;
            end
            HS_WAIT: begin
               if (quiet) begin
                  state_q <= HS_END;
               end
            end
            HS_END: begin
               state_q <= HS_IDLE;
               dma_q <= 1'b0;
               busy_q <= 1'b0;
            end
            default: state_q <= HS_IDLE;
         endcase
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         cmd_q <= 8'h00;
         dh_q <= 8'h00;
         ch_q <= 8'h00;
         cl_q <= 8'h00;
         sn_q <= 8'h00;
         sc_q <= 8'h00;
      end else if ((state_q == HS_IDLE) && go) begin
         cmd_q <= go_cmd;
         dh_q <= go_dev_head;
         ch_q <= go_cyl_hi;
         cl_q <= go_cyl_lo;
         sn_q <= go_sec_num;
         sc_q <= go_sec_cnt;
      end
   end

   // ****************************************
   // Data intake
   // ****************************************
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         ready_q <= 1'b0;
         rx_valid_q <= 1'b0;
         rx_byte_q <= 1'b0;
         rx_word_q <= 16'h0000;
      end else begin
         // DMA words only under DMARQ; PIO words while DRQ holds
         ready_q <= (state_q == HS_WAIT) && !rx_stall
                    && (dma_q ? link.dmarq : link.drq);
         rx_valid_q <= taken;
         if (taken) begin
            rx_word_q <= link.data;
            rx_byte_q <= link.data_byte;
         end
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         done_q <= 1'b0;
         done_err_q <= 1'b0;
         err_reg_q <= 8'h00;
         addr_q <= '0;
      end else begin
         done_q <= (state_q == HS_WAIT) && quiet;
         if ((state_q == HS_WAIT) && quiet) begin
            done_err_q <= link.err;
            err_reg_q <= link.err_reg;
            addr_q <= {link.tf_head[3:0], link.tf_cyl_hi, link.tf_cyl_lo, link.tf_sec_num};
         end
      end
   end

   assign link.cmd_stb = stb_q;
   assign link.cmd = cmd_q;
   assign link.dev_head = dh_q;
   assign link.cyl_hi = ch_q;
   assign link.cyl_lo = cl_q;
   assign link.sec_num = sn_q;
   assign link.sec_cnt = sc_q;
   assign link.data_ready = ready_q;
   assign busy = busy_q;
   assign rx_word = rx_word_q;
   assign rx_byte = rx_byte_q;
   assign rx_valid = rx_valid_q;
   assign done = done_q;
   assign done_err = done_err_q;
   assign done_err_reg = err_reg_q;
   assign done_addr = addr_q;
endmodule // ard_host_end
`default_nettype wire

// File: tb/ard_link_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module ard_link_monitor import ard_pkg::*; #(
   parameter logic DRIVE = 1'b0
) (
   input wire logic clock,
   input wire logic arst_n,
   input wire logic cmd_stb,
   input wire logic [7:0] cmd,
   input wire logic [7:0] dev_head,
   input wire logic bsy,
   input wire logic drq,
   input wire logic dmarq,
   input wire logic err,
   input wire logic intrq,
   input wire logic [7:0] err_reg,
   input wire logic [15:0] data,
   input wire logic data_byte,
   input wire logic data_valid,
   input wire logic data_ready
);
   logic acc;
   logic pop;
   logic dma_q;
   logic [8:0] wcnt_q;
   assign acc = cmd_stb && dev_head[4] == DRIVE && !bsy && !drq && !dma_q;
   assign pop = data_valid && data_ready;
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         dma_q <= 1'b0;
      end else if (acc && cmd == CMD_RD_DMA) begin
         dma_q <= 1'b1;
      end else if (intrq) begin
         dma_q <= 1'b0;
      end
   end
   // Words popped in the current data phase
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         wcnt_q <= 9'h000;
      end else if (!drq) begin
         wcnt_q <= 9'h000;
      end else if (pop && !data_byte) begin
         wcnt_q <= wcnt_q + 9'h001;
      end
   end
   default clocking @(posedge clock); endclocking
   default disable iff (!arst_n);
   a_nop_abort: assert property (acc && cmd == CMD_NOP |=> err && err_reg == ERR_ABRT ##1 intrq)
      else $error("no-op not aborted");
   a_dma_paced: assert property (dma_q && pop |-> dmarq)
      else $error("dma word moved without dmarq");
   a_dma_irq_end: assert property (dma_q && intrq |-> !drq && !dmarq && !bsy)
      else $error("dma interrupt before end");
   a_dma_status: assert property (dma_q && !bsy && !drq |-> ##[0:1] intrq)
      else $error("dma status dropped early");
   a_block_irq: assert property ($rose(drq) && !dmarq |-> intrq)
      else $error("block start without interrupt");
   a_sector_words: assert property (pop && !data_byte |-> wcnt_q < SECT_WORDS)
      else $error("too many words in sector");
   a_ecc_after_words: assert property (pop && data_byte |-> wcnt_q == SECT_WORDS)
      else $error("byte item before sector words");
   a_data_drq: assert property (data_valid |-> drq)
      else $error("data offered without drq");
   a_valid_hold: assert property (data_valid && !data_ready |=> data_valid && $stable(data))
      else $error("stalled word changed");
   a_other_drive: assert property (cmd_stb && dev_head[4] != DRIVE && !bsy && !drq
      |=> !bsy && !intrq ##1 !bsy && !intrq)
      else $error("other drive command acted on");
   a_native_quick: assert property (acc && cmd == CMD_NATIVE_MAX |=> !bsy ##1 intrq)
      else $error("native max answer late");
   c_nop: cover property (acc && cmd == CMD_NOP);
   c_dma_end: cover property (dma_q && intrq);
   c_ecc: cover property (pop && data_byte);
   c_stall: cover property (data_valid && !data_ready);
endmodule // ard_link_monitor
`default_nettype wire

// File: tb/tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb import ard_pkg::*;;
   logic clock, arst_n, go, rx_stall, stall_en, mult_enable, unc_en, corr_en;
   logic busy, rx_byte, rx_valid, done, done_err, media_req, media_ready;
   logic [7:0] go_cmd, go_dev_head, go_cyl_hi, go_cyl_lo, go_sec_num, go_sec_cnt;
   logic [7:0] done_err_reg, ident_max_mult, mcnt;
   logic [15:0] rx_word, fw, lw;
   logic [27:0] done_addr, media_lba, native_max, bad;
   int errors, tests_run, nw, nb, ni;
   ard_link_if i_ard_link_if();
   ard_dev_end i_ard_dev_end (.clock(clock), .arst_n(arst_n), .link(i_ard_link_if.dev),
      .drive_num(1'b0), .mult_enable(mult_enable), .mult_count(8'h04),
      .native_max(native_max), .media_req(media_req), .media_lba(media_lba),
      .media_word({media_lba[7:0], media_req ? 8'h00 : mcnt}), .media_valid(1'b1),
      .media_ready(media_ready),
      .media_err_corr(corr_en && media_lba == bad), .media_err_unc(unc_en && media_lba == bad),
      .ident_max_mult(ident_max_mult));
   ard_host_end i_ard_host_end (.clock(clock), .arst_n(arst_n), .link(i_ard_link_if.host),
      .go(go), .go_cmd(go_cmd), .go_dev_head(go_dev_head), .go_cyl_hi(go_cyl_hi),
      .go_cyl_lo(go_cyl_lo), .go_sec_num(go_sec_num), .go_sec_cnt(go_sec_cnt),
      .rx_stall(rx_stall), .busy(busy), .rx_word(rx_word), .rx_byte(rx_byte),
      .rx_valid(rx_valid), .done(done), .done_err(done_err), .done_err_reg(done_err_reg),
      .done_addr(done_addr));
   ard_link_monitor i_ard_link_monitor (.clock(clock), .arst_n(arst_n),
      .cmd_stb(i_ard_link_if.cmd_stb), .cmd(i_ard_link_if.cmd),
      .dev_head(i_ard_link_if.dev_head), .bsy(i_ard_link_if.bsy), .drq(i_ard_link_if.drq),
      .dmarq(i_ard_link_if.dmarq), .err(i_ard_link_if.err), .intrq(i_ard_link_if.intrq),
      .err_reg(i_ard_link_if.err_reg), .data(i_ard_link_if.data),
      .data_byte(i_ard_link_if.data_byte), .data_valid(i_ard_link_if.data_valid),
      .data_ready(i_ard_link_if.data_ready));
   initial begin
      clock = 1'b0;
      forever #10 clock = ~clock;
   end
   // Media words carry the sector number and word index
   // First word of a sector is taken in the same cycle as the fetch pulse
   always @(posedge clock) begin
      if (media_ready) mcnt <= media_req ? 8'h01 : mcnt + 8'h01;
   end
   always @(posedge clock) begin
      if (rx_valid && rx_byte) nb++;
      if (rx_valid && !rx_byte) begin
         if (nw == 0) fw = rx_word;
         lw = rx_word;
         nw++;
      end
      if (i_ard_link_if.intrq === 1'b1) ni++;
   end
   always @(negedge clock) rx_stall <= stall_en && !rx_stall;
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         errors++;
         $display("unexpected at %0t: got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic run(input logic [7:0] c, input logic [7:0] dh, input logic [23:0] a,
      input logic [7:0] n);
      int k;
      @(negedge clock);
      nw = 0; nb = 0; ni = 0;
      go = 1'b1; go_cmd = c; go_dev_head = dh; go_sec_cnt = n;
      {go_cyl_hi, go_cyl_lo, go_sec_num} = a;
      @(negedge clock);
      go = 1'b0;
      k = 0;
      while (done !== 1'b1 && k < 5000) begin
         @(negedge clock);
         k++;
      end
      chk(k < 5000, 1);
      repeat (3) @(negedge clock);
      chk(busy, 0);
   endtask
   task automatic t_cmds();
      run(CMD_NOP, 8'he0, 24'h0, 8'h01);
      chk(done_err_reg, ERR_ABRT);
      run(CMD_RD_BUF, 8'hf0, 24'h0, 8'h01);
      chk(nw + ni, 0);
      stall_en = 1'b1;
      run(CMD_RD_DMA, 8'he3, 24'h123456, 8'h02);
      stall_en = 1'b0;
      chk(nw, 512);
      chk({fw, lw}, 32'h5600_57ff);
      chk(ni, 1);
      chk(done_addr, 28'h3123457);
   endtask
   task automatic t_mult();
      mult_enable = 1'b0;
      run(CMD_RD_MULT, 8'he0, 24'h0000fe, 8'h03);
      chk(done_err_reg, ERR_ABRT);
      mult_enable = 1'b1;
      run(CMD_RD_MULT, 8'he0, 24'h0000fe, 8'h03);
      chk(nw, 768);
      chk(ni, 3);
      chk(ident_max_mult, MAX_MULT);
      chk(done_addr, 28'h0000100);
      unc_en = 1'b1;
      run(CMD_RD_MULT, 8'he0, 24'h000010, 8'h03);
      chk(nw, 512);
      chk({done_err, done_err_reg[6]}, 2'b11);
      chk(done_addr, bad);
      unc_en = 1'b0;
      corr_en = 1'b1;
      run(CMD_RD_MULT, 8'he0, 24'h000010, 8'h03);
      chk(nw, 768);
      chk(i_ard_link_if.corr, 1);
      corr_en = 1'b0;
   endtask
   task automatic t_long();
      unc_en = 1'b1;
      for (int i = 0; i < 2; i++) begin
         run(CMD_RD_LONG0 + 8'(i), 8'he0, 24'h000011, 8'h01);
         chk({nw[15:0], nb[15:0]}, 32'h0100_0004);
         chk(done_err, 0);
      end
      unc_en = 1'b0;
      run(CMD_RD_BUF, 8'he0, 24'h0, 8'h00);
      chk({fw, lw}, 32'h1100_11ff);
      run(CMD_NATIVE_MAX, 8'he0, 24'h0, 8'h00);
      chk(done_addr, native_max);
   endtask
   task automatic test_done();
      $display("errors %0d tests_run %0d", errors, tests_run);
      if (errors == 0 && tests_run > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   initial begin
      #(20 * 40000);
      errors++;
      test_done();
   end
   initial begin
      arst_n = 1'b0; go = 1'b0; stall_en = 1'b0; rx_stall = 1'b0; mult_enable = 1'b0;
      unc_en = 1'b0; corr_en = 1'b0; native_max = 28'h9abcdef; bad = 28'h0000011;
      go_cmd = 8'h00; go_dev_head = 8'h00; go_cyl_hi = 8'h00; go_cyl_lo = 8'h00;
      go_sec_num = 8'h00; go_sec_cnt = 8'h00; errors = 0; tests_run = 0; mcnt = 8'h00;
      repeat (3) @(posedge clock);
      @(negedge clock) arst_n = 1'b1;
      t_cmds();
      t_mult();
      t_long();
      test_done();
   end
endmodule // tb
`default_nettype wire
